// *** bench/lmir_host.sv ***
// host processor model on the control port
`timescale 1ns/100ps
`default_nettype none
module lmir_host
	import lmir_pkg::*;
(
	// clock
	input  wire logic              mclk_i,
	// control port
	output logic      [ADDR_W-1:0] cpu_addr_o,
	output logic                   cpu_wr_o,
	output logic                   cpu_rd_o,
	output logic      [DATA_W-1:0] cpu_wdata_o,
	input  wire logic [DATA_W-1:0] cpu_rdata_i
);
	initial begin
		cpu_addr_o = 8'h00;
		cpu_wr_o = 1'b0;
		cpu_rd_o = 1'b0;
		cpu_wdata_o = 8'h00;
	end
	// strobe held across one rising edge, data inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		cpu_addr_o = a;
		cpu_wdata_o = d;
		cpu_wr_o = 1'b1;
		@(negedge mclk_i);
		cpu_wr_o = 1'b0;
		cpu_wdata_o = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		cpu_addr_o = a;
		cpu_rd_o = 1'b1;
		@(negedge mclk_i);
		d = cpu_rdata_i;
		cpu_rd_o = 1'b0;
	endtask
	// transfer bit is put back to 0 so the next request makes a fresh edge
	task automatic xfer(input logic [7:0] a, input logic [7:0] ctrl);
		wr(a, ctrl | 8'h01);
		wr(a, ctrl);
	endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the maintenance and interrupt-mask register group
`timescale 1ns/100ps
`default_nettype none
module testbench
	import lmir_pkg::*;
;
	localparam logic [7:0]  RV  [7] = '{8'h01, 8'h01, 8'h09, 8'h00, 8'hFF, 8'hFF, 8'h00};
	localparam logic [15:0] EXP [4] = '{16'h0001, 16'h0002, 16'h0002, 16'h0004};
	logic           mclk = 1'b0;
	logic           rst_n = 1'b0;
	logic [7:0]     addr;
	logic [7:0]     wdata;
	logic [7:0]     rdata;
	logic           wr;
	logic           rd;
	logic [7:0]     d;
	lmir_chan_in_s  [3:0] chan_in;
	lmir_chan_out_s [3:0] chan_out;
	int             miscompares = 0;
	int             n_compared = 0;
	int             nbpv = 0;
	int             npat = 0;

	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		nbpv <= nbpv + int'(chan_out[0].bpv_insert === 1'b1);
		npat <= npat + int'(chan_out[0].pat_err_insert === 1'b1);
	end

	lmir_regs #(.NCH(4)) dut_u (
		.mclk_i(mclk),
		.rst_n_i(rst_n),
		.cpu_addr_i(addr),
		.cpu_wr_i(wr),
		.cpu_rd_i(rd),
		.cpu_wdata_i(wdata),
		.cpu_rdata_o(rdata),
		.chan_i(chan_in),
		.chan_o(chan_out)
	);
	lmir_host host_u (
		.mclk_i(mclk),
		.cpu_addr_o(addr),
		.cpu_wr_o(wr),
		.cpu_rd_o(rd),
		.cpu_wdata_o(wdata),
		.cpu_rdata_i(rdata)
	);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one-cycle event and flag-clear pulses on channel 0
	task automatic pulse(input logic [7:0] e, input logic [15:0] f);
		@(negedge mclk);
		chan_in[0].err_event = e;
		chan_in[0].flag_clear = f;
		@(negedge mclk);
		chan_in[0].err_event = 8'h00;
		chan_in[0].flag_clear = 16'h0000;
	endtask
	task automatic close_out;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		close_out();
	end

	initial begin
		for (int c = 0; c < 4; c++) begin
			chan_in[c] = '0;
		end
		repeat (8) @(negedge mclk);
		rst_n = 1'b1;
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 7; r++) begin
				host_u.rd({c[1:0], OFF_CODE_LEN + r[5:0]}, d);
				chk("reset value", RV[r], d);
			end
			host_u.wr({c[1:0], OFF_ACT_CODE}, 8'hA0 + c[7:0]);
			host_u.wr({c[1:0], OFF_DEACT_CODE}, 8'h30 + c[7:0]);
		end
		for (int c = 0; c < 4; c++) begin
			host_u.rd({c[1:0], OFF_ACT_CODE}, d);
			chk("act code", 8'hA0 + c[7:0], d);
			chk("deact port", 8'h30 + c[7:0], chan_out[c].deact_code);
			chk("act port", 8'hA0 + c[7:0], chan_out[c].act_code);
		end
		host_u.rd(8'h20, d);
		chk("unmapped", 8'h00, d);
		host_u.wr(8'h0D, 8'hFF);
		chk("lengths", 4'hF, {chan_out[0].act_len, chan_out[0].deact_len});
		host_u.wr(8'h10, 8'h1E);
		chk("ctrl fields", 4'hF, {chan_out[0].exz_rule, chan_out[0].err_src,
			chan_out[0].report_mode});
		host_u.wr(8'h10, 8'h80);
		host_u.rd(8'h10, d);
		chk("ctrl reserved", 8'h00, d);
		for (int k = 0; k < 2; k++) begin
			host_u.wr(8'h10, 8'h40 >> k);
			host_u.wr(8'h10, 8'h40 >> k);
			host_u.wr(8'h10, 8'h00);
			host_u.wr(8'h10, 8'h40 >> k);
			host_u.wr(8'h10, 8'h00);
		end
		chk("bpv pulses", 16'h0002, nbpv[15:0]);
		chk("pattern pulses", 16'h0002, npat[15:0]);
		for (int s = 0; s < 4; s++) begin
			host_u.wr(8'h10, {4'h0, s[1:0], 2'b00});
			pulse(8'h10, 16'h0000);
			pulse(8'h08, 16'h0000);
			pulse(8'h04, 16'h0000);
			pulse(8'h0C, 16'h0000);
			host_u.xfer(8'h10, {4'h0, s[1:0], 2'b00});
			chk("count", EXP[s], chan_out[0].count_result);
		end
		host_u.wr(8'h10, 8'h02);
		repeat (3) pulse(8'h10, 16'h0000);
		pulse(8'h02, 16'h0000);
		pulse(8'h00, 16'h0000);
		chk("auto count", 16'h0003, chan_out[0].count_result);
		host_u.wr(8'h10, 8'h00);
		for (int i = 0; i < 8; i++) begin
			host_u.wr(8'h12, 8'hFF);
			pulse(8'h01 << i, 16'h0000);
			chk("irq masked", 1'b0, chan_out[0].irq);
			chk("error flag", 1'b1, chan_out[0].flags[i]);
			host_u.wr(8'h12, ~(8'h01 << i));
			chk("irq error", 1'b1, chan_out[0].irq);
			pulse(8'h00, 16'h0001 << i);
			chk("irq cleared", 1'b0, chan_out[0].irq);
		end
		host_u.wr(8'h12, 8'hFF);
		for (int j = 0; j < 8; j++) begin
			host_u.wr(8'h11, ~(8'h01 << j));
			chan_in[0].line_status[j] = 1'b1;
			repeat (2) @(negedge mclk);
			chk("irq line", 1'b1, chan_out[0].irq);
			chk("line flag", 1'b1, chan_out[0].flags[8 + j]);
			pulse(8'h00, 16'h0100 << j);
			chan_in[0].line_status[j] = 1'b0;
			repeat (2) @(negedge mclk);
			chk("irq falling", 1'b0, chan_out[0].irq);
		end
		host_u.wr(8'h13, 8'h80);
		chan_in[0].line_status[7] = 1'b1;
		pulse(8'h00, 16'h8000);
		chan_in[0].line_status[7] = 1'b0;
		repeat (2) @(negedge mclk);
		chk("irq any edge", 1'b1, chan_out[0].irq);
		close_out();
	end
endmodule
`default_nettype wire

// *** rtl/lmir_regs.sv ***
// per channel maintenance, error counter and interrupt-mask register group
`timescale 1ns/100ps
`default_nettype none
module lmir_regs
	import lmir_pkg::*;
#(
	parameter int NCH = 4
) (
	// clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_n_i,
	// control port
	input  wire logic [ADDR_W-1:0]     cpu_addr_i,
	input  wire logic                  cpu_wr_i,
	input  wire logic                  cpu_rd_i,
	input  wire logic [DATA_W-1:0]     cpu_wdata_i,
	output logic      [DATA_W-1:0]     cpu_rdata_o,
	// channel side
	input  wire lmir_chan_in_s [NCH-1:0] chan_i,
	output lmir_chan_out_s [NCH-1:0]   chan_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input int ch,
		input logic [OFF_W-1:0] off);
		hit = (a[ADDR_W-1:CH_LSB] == ch[ADDR_W-CH_LSB-1:0]) && (a[OFF_W-1:0] == off);
	endfunction

	logic [DATA_W-1:0] len_q   [NCH];
	logic [DATA_W-1:0] act_q   [NCH];
	logic [DATA_W-1:0] deact_q [NCH];
	logic [DATA_W-1:0] ctrl_q  [NCH];
	logic [DATA_W-1:0] prev_q  [NCH];
	logic [DATA_W-1:0] mask0_q [NCH];
	logic [DATA_W-1:0] mask1_q [NCH];
	logic [DATA_W-1:0] edge_q  [NCH];
	logic [7:0]        stat_q  [NCH];
	logic [15:0]       flag_q  [NCH];
	logic [CNT_W-1:0]  cnt_q   [NCH];
	logic [CNT_W-1:0]  res_q   [NCH];
	logic              bpv_q   [NCH];
	logic              pat_q   [NCH];
	logic [NCH-1:0]    xfer;
	logic [NCH-1:0]    ovf;
	logic [NCH-1:0]    irq;

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			logic [1:0]  inc;
			logic [15:0] set;
			logic [7:0]  chg;

			// configuration registers
			always_ff @(posedge mclk_i) begin
				if (!rst_n_i) begin
					len_q[c]   <= RST_CODE_LEN; // R15 R16
					act_q[c]   <= RST_ACT_CODE; // R1
					deact_q[c] <= RST_DEACT_CODE; // R2
					ctrl_q[c]  <= RST_ZERO;
					mask0_q[c] <= RST_MASK; // R10
					mask1_q[c] <= RST_MASK; // R10
					edge_q[c]  <= RST_ZERO;
				end else if (cpu_wr_i) begin
					if (hit(cpu_addr_i, c, OFF_CODE_LEN))
						len_q[c] <= cpu_wdata_i & LEN_WMASK; // R15 R16
					if (hit(cpu_addr_i, c, OFF_ACT_CODE))
						act_q[c] <= cpu_wdata_i; // R1 R14
					if (hit(cpu_addr_i, c, OFF_DEACT_CODE))
						deact_q[c] <= cpu_wdata_i; // R2 R14
					if (hit(cpu_addr_i, c, OFF_ERR_CTRL))
						ctrl_q[c] <= cpu_wdata_i & CTRL_WMASK; // R14
					if (hit(cpu_addr_i, c, OFF_LINE_MASK))
						mask0_q[c] <= cpu_wdata_i; // R11
					if (hit(cpu_addr_i, c, OFF_ERR_MASK))
						mask1_q[c] <= cpu_wdata_i; // R12 R13
					if (hit(cpu_addr_i, c, OFF_EDGE_SEL))
						edge_q[c] <= cpu_wdata_i; // R17
				end
			end

			// one-shot insert strobes, only a fresh 0-to-1 of the control bit fires
			always_ff @(posedge mclk_i) begin
				if (!rst_n_i) begin
					prev_q[c] <= RST_ZERO;
					bpv_q[c]  <= 1'b0;
					pat_q[c]  <= 1'b0;
				end else begin
					prev_q[c] <= ctrl_q[c];
					bpv_q[c]  <= ctrl_q[c][BIT_BIPOLAR_VIOLATION_INSERT] & ~prev_q[c][BIT_BIPOLAR_VIOLATION_INSERT]; // R3
					pat_q[c]  <= ctrl_q[c][BIT_PAT_INS] & ~prev_q[c][BIT_PAT_INS]; // R4
				end
			end

			// manual edge relies on the host clearing the bit between requests
			assign xfer[c] = (ctrl_q[c][BIT_XFER] & ~prev_q[c][BIT_XFER]) // R8 R9
				| (ctrl_q[c][BIT_MODE] & chan_i[c].err_event[EV_TIMER]); // R7 R19

			always_comb begin
				inc = 2'h0;
				case (ctrl_q[c][BIT_SRC_LSB +: 2]) // R6
					SRC_PATTERN: inc = {1'b0, chan_i[c].err_event[EV_PAT_ERR]};
					SRC_EXZ:     inc = {1'b0, chan_i[c].err_event[EV_EXZ]};
					SRC_CV:      inc = {1'b0, chan_i[c].err_event[EV_CV]};
					SRC_BOTH:    inc = 2'(chan_i[c].err_event[EV_CV])
						+ 2'(chan_i[c].err_event[EV_EXZ]);
					default:     inc = 2'h0;
				endcase
			end
			assign ovf[c] = (inc != 2'h0) && (cnt_q[c] > CNT_MAX - CNT_W'(inc));

			// error counter: saturates so an overflowed count never looks small
			always_ff @(posedge mclk_i) begin
				if (!rst_n_i) begin
					cnt_q[c] <= '0;
					res_q[c] <= '0;
				end else if (xfer[c]) begin
					res_q[c] <= cnt_q[c]; // R8
					cnt_q[c] <= '0; // R8
				end else if (ovf[c]) begin
					cnt_q[c] <= CNT_MAX;
				end else begin
					cnt_q[c] <= cnt_q[c] + CNT_W'(inc); // R6
				end
			end

			// sticky event flags: a set in the clear cycle wins
			assign chg = (chan_i[c].line_status & ~stat_q[c])
				| (edge_q[c] & ~chan_i[c].line_status & stat_q[c]); // R17
			assign set = {chg, chan_i[c].err_event | {7'h00, ovf[c]}};
			always_ff @(posedge mclk_i) begin
				if (!rst_n_i) begin
					stat_q[c] <= RST_ZERO;
					flag_q[c] <= '0;
				end else begin
					stat_q[c] <= chan_i[c].line_status;
					flag_q[c] <= (flag_q[c] & ~chan_i[c].flag_clear) | set;
				end
			end
			assign irq[c] = |(flag_q[c] & ~{mask0_q[c], mask1_q[c]}); // R18 R10

			always_comb begin
				chan_o[c].act_code       = act_q[c];
				chan_o[c].act_len        = len_q[c][BIT_ALEN_LSB +: 2];
				chan_o[c].deact_code     = deact_q[c];
				chan_o[c].deact_len      = len_q[c][BIT_DLEN_LSB +: 2];
				chan_o[c].exz_rule       = ctrl_q[c][BIT_EXZ_RULE]; // R5
				chan_o[c].err_src        = ctrl_q[c][BIT_SRC_LSB +: 2];
				chan_o[c].report_mode    = ctrl_q[c][BIT_MODE];
				chan_o[c].bpv_insert     = bpv_q[c];
				chan_o[c].pat_err_insert = pat_q[c];
				chan_o[c].count_result   = res_q[c];
				chan_o[c].flags          = flag_q[c];
				chan_o[c].irq            = irq[c];
			end

			bpv_edge_a: assert property ( // R3
				bpv_q[c] |-> prev_q[c][BIT_BIPOLAR_VIOLATION_INSERT] && !$past(prev_q[c][BIT_BIPOLAR_VIOLATION_INSERT]))
				else $error("violation insert without a rising control bit");
			bpv_single_a: assert property ( // R3
				bpv_q[c] |=> !bpv_q[c])
				else $error("violation insert longer than one cycle");
			pat_edge_a: assert property ( // R4
				$rose(ctrl_q[c][BIT_PAT_INS]) |=> pat_q[c] ##1 !pat_q[c])
				else $error("pattern error insert not a single pulse");
			irq_mask_a: assert property ( // R18
				(flag_q[c][15:8] & ~mask0_q[c]) == 8'h00
				&& (flag_q[c][7:0] & ~mask1_q[c]) == 8'h00 |-> !chan_o[c].irq)
				else $error("interrupt from masked or absent event");
			xfer_result_a: assert property ( // R8
				xfer[c] |=> res_q[c] == $past(cnt_q[c]) && cnt_q[c] == '0)
				else $error("count transfer did not copy and clear");
			auto_xfer_a: assert property ( // R19
				ctrl_q[c][BIT_MODE] && chan_i[c].err_event[EV_TIMER]
				|=> cnt_q[c] == '0 && res_q[c] == $past(cnt_q[c]))
				else $error("automatic transfer missed on timer expiry");
			act_write_a: assert property ( // R14
				cpu_wr_i && hit(cpu_addr_i, c, OFF_ACT_CODE)
				|=> act_q[c] == $past(cpu_wdata_i))
				else $error("activate code write not stored");
			rise_flag_a: assert property ( // R17
				chan_i[c].line_status[0] && !stat_q[c][0] |=> flag_q[c][8])
				else $error("rising status did not set its flag");
			fall_flag_a: assert property ( // R17
				!chan_i[c].line_status[0] && stat_q[c][0] && edge_q[c][0] |=> flag_q[c][8])
				else $error("falling status with any-edge did not set flag");
			pat_count_a: assert property ( // R6
				ctrl_q[c][BIT_SRC_LSB +: 2] == SRC_PATTERN && chan_i[c].err_event[EV_PAT_ERR]
				&& !xfer[c] && !ovf[c] |=> cnt_q[c] == $past(cnt_q[c]) + 16'h0001)
				else $error("pattern error not counted");
		end
	endgenerate

	// readback; a read of any other offset answers zero
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cpu_rdata_o <= RST_ZERO;
		end else if (cpu_rd_i) begin
			cpu_rdata_o <= RST_ZERO;
			for (int i = 0; i < NCH; i++) begin
				if (hit(cpu_addr_i, i, OFF_CODE_LEN))   cpu_rdata_o <= len_q[i];
				if (hit(cpu_addr_i, i, OFF_ACT_CODE))   cpu_rdata_o <= act_q[i];
				if (hit(cpu_addr_i, i, OFF_DEACT_CODE)) cpu_rdata_o <= deact_q[i];
				if (hit(cpu_addr_i, i, OFF_ERR_CTRL))   cpu_rdata_o <= ctrl_q[i];
				if (hit(cpu_addr_i, i, OFF_LINE_MASK))  cpu_rdata_o <= mask0_q[i];
				if (hit(cpu_addr_i, i, OFF_ERR_MASK))   cpu_rdata_o <= mask1_q[i];
				if (hit(cpu_addr_i, i, OFF_EDGE_SEL))   cpu_rdata_o <= edge_q[i];
			end
		end
	end
endmodule
`default_nettype wire

// *** shared/lmir_pkg.sv ***
// constants, field layout and carrier types of the maintenance and interrupt-mask register group
// Overview of operation
// R1: per channel 8-bit receive activate code, low 5-8 bits used, default 00001
// R2: per channel 8-bit receive deactivate code, low 5-8 bits used, default 001001
// R3: rising edge of violation-insert bit inserts exactly one bipolar violation
// R4: rising edge of pattern-error-insert bit inserts exactly one pattern logic error
// R5: excess-zero rule select: 0 picks ANSI, 1 picks FCC
// R6: error source: 00 pattern, 01 excess zero, 10 code violation, 11 both
// R7: report mode bit: 0 manual, 1 automatic
// R8: rising edge of transfer bit copies count to result, then clears counter
// R9: host writes transfer bit to 0 before the next manual transfer
// R10: mask bit 0 enables, 1 masks; all masks reset to 1
// R11: line mask bits 6..0: activate, deactivate, sync, clock loss, driver, alarm, loss
// R12: error mask bits 7..4: DAC overflow, jitter over, jitter under, pattern error
// R13: error mask bits 3..0: excess zeros, code errors, second timer, counter overflow
// R14: each register repeats per channel at bases 0x00, 0x40, 0x80, 0xC0
// R15: activate length field selects 5-8 bit code, reset 00
// R16: deactivate length field selects 5-8 bit code, reset 01
// R17: line edge select: 0 rising transition, 1 any transition of status
// R18: interrupt output asserts only for set flags whose mask bit is 0
// R19: automatic mode transfers and clears counter on each second-timer expiry
package lmir_pkg;
	localparam int         ADDR_W         = 8;
	localparam int         DATA_W         = 8;
	localparam int         CNT_W          = 16;
	localparam int         CH_LSB         = 6;
	localparam int         OFF_W          = 6;
	localparam logic [5:0] OFF_CODE_LEN   = 6'h0D;
	localparam logic [5:0] OFF_ACT_CODE   = 6'h0E;
	localparam logic [5:0] OFF_DEACT_CODE = 6'h0F;
	localparam logic [5:0] OFF_ERR_CTRL   = 6'h10;
	localparam logic [5:0] OFF_LINE_MASK  = 6'h11;
	localparam logic [5:0] OFF_ERR_MASK   = 6'h12;
	localparam logic [5:0] OFF_EDGE_SEL   = 6'h13;
	localparam logic [7:0] RST_ACT_CODE   = 8'h01;
	localparam logic [7:0] RST_DEACT_CODE = 8'h09;
	localparam logic [7:0] RST_CODE_LEN   = 8'h01;
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_MASK       = 8'hFF;
	localparam logic [7:0] CTRL_WMASK     = 8'h7F;
	localparam logic [7:0] LEN_WMASK      = 8'h0F;
	localparam int         BIT_BIPOLAR_VIOLATION_INSERT    = 6;
	localparam int         BIT_PAT_INS    = 5;
	localparam int         BIT_EXZ_RULE   = 4;
	localparam int         BIT_SRC_LSB    = 2;
	localparam int         BIT_MODE       = 1;
	localparam int         BIT_XFER       = 0;
	localparam int         BIT_ALEN_LSB   = 2;
	localparam int         BIT_DLEN_LSB   = 0;
	localparam int         EV_PAT_ERR     = 4;
	localparam int         EV_EXZ         = 3;
	localparam int         EV_CV          = 2;
	localparam int         EV_TIMER       = 1;
	localparam int         EV_CNT_OVF     = 0;
	localparam logic [1:0] SRC_PATTERN    = 2'h0;
	localparam logic [1:0] SRC_EXZ        = 2'h1;
	localparam logic [1:0] SRC_CV         = 2'h2;
	localparam logic [1:0] SRC_BOTH       = 2'h3;
	localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;

	// per channel inputs from the line logic and the status-register read side
	typedef struct packed {
		logic [7:0]  line_status;
		logic [7:0]  err_event;
		logic [15:0] flag_clear;
	} lmir_chan_in_s;

	// per channel settings and results handed to the line logic
	typedef struct packed {
		logic [7:0]       act_code;
		logic [1:0]       act_len;
		logic [7:0]       deact_code;
		logic [1:0]       deact_len;
		logic             exz_rule;
		logic [1:0]       err_src;
		logic             report_mode;
		logic             bpv_insert;
		logic             pat_err_insert;
		logic [CNT_W-1:0] count_result;
		logic [15:0]      flags;
		logic             irq;
	} lmir_chan_out_s;
endpackage
